// [ises_top.v]
// Purpose: Event status, parallel-poll summary and operation status logic
// Assumes: Commands arrive already decoded from the bus parser on clk
// Notes:   Each rule below is tagged at the logic that keeps it
// Overview of operation
// R01: IST is OR of status byte AND mask
// R02: IST answers parallel poll and IST query
// R03: Parallel-poll mask written and read back unchanged
// R04: Latched event status returned on its query
// R05: Event enable mask stored and read back
// R06: OPC sets bit 0 once prior commands finish
// R07: Bit 1 set on controller-role request
// R08: Bit 2 set on query protocol error
// R09: Bit 3 and device error code queued; code not pushed when a command or execution error comes in the same cycle
// R10: Bit 4 and execution error code queued; code not pushed when a command error comes in the same cycle
// R11: Bit 5 and command error code queued
// R12: Bit 6 set on local key press
// R13: Bit 7 set at power-up
// R14: Operation condition and event views readable
// R15: Condition bits follow calibrate, range, sweep, measure
// R16: Settling bit only beyond command processing time
// R17: Trigger, arm and correction wait bits held
// R18: Device bits, instrument summary, program running
// R19: Operation bit 15 always reads zero
// R20: Operation register may be left inactive
// R21: Status bit 5 from enabled events
// R22: Status bit 7 from enabled operation events
// R23: Event reads clear; operation events latch rises
// R24: Masks clear, power-on bit set after reset
`timescale 1ns/100ps
`default_nettype none

`include "ises_map.vh"

module ises_top #(
    parameter OP_IMPL      = 1,
    parameter SETTLE_CYC   = `ISES_CMD_PROC_CYC
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Decoded command port
    input  wire        cmd_valid,
    input  wire [3:0]  cmd_code,
    input  wire [15:0] cmd_data,
    // Query answer
    output reg         rsp_valid_r,
    output reg  [15:0] rsp_data_r,
    // Event sources on clk; exec_idle is a level, the rest one-cycle pulses
    input  wire        exec_idle,
    input  wire        ctl_request,
    input  wire        query_err,
    input  wire        devdep_err,
    input  wire        exec_err,
    input  wire        command_err,
    // Front-panel local key pin, asynchronous
    input  wire        local_key,
    // Operation activity levels on clk
    input  wire        calibrating,
    input  wire        settling,
    input  wire        ranging,
    input  wire        sweeping,
    input  wire        measuring,
    input  wire        wait_trigger,
    input  wire        wait_arm,
    input  wire        correcting,
    input  wire [4:0]  dev_activity,
    input  wire        inst_summary,
    input  wire        prog_running,
    // Status byte bits built elsewhere
    input  wire [7:0]  stb_ext,
    // Summaries
    output reg  [7:0]  stb_r,
    output reg         ist_r,
    // Error queue push
    output reg         err_push_r,
    output reg  [15:0] err_code_r
);

    localparam [3:0] CMD_RD_IST = `ISES_CMD_RD_IST;

    reg  [7:0]  ppmask_r;
    reg  [7:0]  evmask_r;
    reg  [15:0] opmask_r;
    reg         opc_pend_r;
    reg  [15:0] opcond_r;
    reg  [15:0] opcond_prev_r;
    reg  [15:0] settle_cnt_r;
    reg         key_prev_r;
    reg         rsp_valid_nxt;
    reg  [15:0] rsp_data_nxt;
    reg  [7:0]  stb_nxt;
    reg  [15:0] opcond_nxt;
    reg  [7:0]  ev_set;
    reg         opc_done;
    reg         err_push_nxt;
    reg  [15:0] err_code_nxt;

    wire        key_sync;
    wire [7:0]  evstat;
    wire [15:0] opevt;
    wire        rd_evstat;
    wire        rd_opevt;
    wire        settle_long;

    assign rd_evstat   = cmd_valid && (cmd_code == `ISES_CMD_RD_EVSTAT);
    assign rd_opevt    = cmd_valid && (cmd_code == `ISES_CMD_RD_OPEVT);
    assign settle_long = (settle_cnt_r >= SETTLE_CYC[15:0]);

    // Local key comes from the front panel on its own timing
    ises_sync3 #(
        .W (1)
    ) u_key_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (local_key),
        .q     (key_sync)
    );

    // Masks and OPC bookkeeping
    always @(posedge clk) begin
        if (!rst_n) begin
            ppmask_r   <= `ISES_PPMASK_RST;              // see R24
            evmask_r   <= `ISES_EVMASK_RST;              // see R24
            opmask_r   <= `ISES_OPMASK_RST;
            opc_pend_r <= 1'b0;
            key_prev_r <= 1'b0;
        end else begin
            key_prev_r <= key_sync;
            if (cmd_valid && cmd_code == `ISES_CMD_WR_PPMASK) begin
                ppmask_r <= cmd_data[7:0];               // see R03
            end
            if (cmd_valid && cmd_code == `ISES_CMD_WR_EVMASK) begin
                evmask_r <= cmd_data[7:0];               // see R05
            end
            if (cmd_valid && cmd_code == `ISES_CMD_WR_OPMASK) begin
                opmask_r <= cmd_data;
            end
            // A fresh OPC re-arms; completion drops the pending flag
            if (cmd_valid && cmd_code == `ISES_CMD_OPC) begin
                opc_pend_r <= 1'b1;
            end else if (opc_done) begin
                opc_pend_r <= 1'b0;
            end
        end
    end

    // Completion waits one cycle after OPC so the parser can drop idle
    always @* begin
        opc_done = opc_pend_r && exec_idle;              // see R06
    end

    // Event sources into the latched event status
    always @* begin
        ev_set                    = 8'h00;
        ev_set[`ISES_EV_OPC]      = opc_done;            // see R06
        ev_set[`ISES_EV_REQCTL]   = ctl_request;         // see R07
        ev_set[`ISES_EV_QUERY]    = query_err;           // see R08
        ev_set[`ISES_EV_DEVDEP]   = devdep_err;          // see R09
        ev_set[`ISES_EV_EXEC]     = exec_err;            // see R10
        ev_set[`ISES_EV_CMD]      = command_err;         // see R11
        ev_set[`ISES_EV_USER]     = key_sync && !key_prev_r; // see R12
        ev_set[`ISES_EV_PON]      = 1'b0;
    end

    // Power-on bit comes from the reset value of the latch
    ises_evlatch #(
        .W   (8),
        .RST (`ISES_EVSTAT_RST)                          // see R13
    ) u_evstat (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (ev_set),
        .clr   (rd_evstat),                              // see R23
        .q     (evstat)                                  // see R04
    );

    // Error queue push; only one code fits per cycle, so the
    // command error takes priority over execution and device faults
    always @* begin
        err_push_nxt = 1'b0;
        err_code_nxt = 16'h0000;
        if (command_err) begin
            err_push_nxt = 1'b1;
            err_code_nxt = `ISES_ERR_CMD;                // see R11
        end else if (exec_err) begin
            err_push_nxt = 1'b1;
            err_code_nxt = `ISES_ERR_EXEC;               // see R10
        end else if (devdep_err) begin
            err_push_nxt = 1'b1;
            err_code_nxt = `ISES_ERR_DEVDEP;             // see R09
        end
    end

    // Settling only counts once it outlasts command processing
    always @(posedge clk) begin
        if (!rst_n) begin
            settle_cnt_r <= 16'h0000;
        end else if (!settling) begin
            settle_cnt_r <= 16'h0000;
        end else if (!settle_long) begin
            settle_cnt_r <= settle_cnt_r + 16'h0001;     // see R16
        end
    end

    // Operation condition view
    always @* begin
        opcond_nxt                                 = 16'h0000;
        opcond_nxt[`ISES_OP_CAL]                   = calibrating;  // see R15
        opcond_nxt[`ISES_OP_SETTLE]                = settling && settle_long; // see R16
        opcond_nxt[`ISES_OP_RANGE]                 = ranging;      // see R15
        opcond_nxt[`ISES_OP_SWEEP]                 = sweeping;     // see R15
        opcond_nxt[`ISES_OP_MEAS]                  = measuring;    // see R15
        opcond_nxt[`ISES_OP_WTRIG]                 = wait_trigger; // see R17
        opcond_nxt[`ISES_OP_WARM]                  = wait_arm;     // see R17
        opcond_nxt[`ISES_OP_CORR]                  = correcting;   // see R17
        opcond_nxt[`ISES_OP_DEV_HI:`ISES_OP_DEV_LO] = dev_activity; // see R18
        opcond_nxt[`ISES_OP_INST]                  = inst_summary; // see R18
        opcond_nxt[`ISES_OP_PROG]                  = prog_running; // see R18
        opcond_nxt[`ISES_OP_ZERO]                  = 1'b0;         // see R19
        if (OP_IMPL == 0) begin
            opcond_nxt = 16'h0000;                                 // see R20
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            opcond_r      <= 16'h0000;
            opcond_prev_r <= 16'h0000;
        end else begin
            opcond_r      <= opcond_nxt;
            opcond_prev_r <= opcond_r;
        end
    end

    // Operation events latch rising edges of the condition view
    ises_evlatch #(
        .W   (16),
        .RST (16'h0000)
    ) u_opevt (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (opcond_r & ~opcond_prev_r),              // see R23
        .clr   (rd_opevt),                               // see R23
        .q     (opevt)
    );

    // Status byte: summaries replace the external bits 5 and 7
    always @* begin
        stb_nxt                 = stb_ext;
        stb_nxt[`ISES_STB_ESB]  = |(evstat & evmask_r);  // see R21
        stb_nxt[`ISES_STB_OPER] = |(opevt & opmask_r);   // see R22
    end

    // Query answers
    always @* begin
        rsp_valid_nxt = 1'b0;
        rsp_data_nxt  = 16'h0000;
        if (cmd_valid) begin
            case (cmd_code)
                `ISES_CMD_RD_PPMASK: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = {8'h00, ppmask_r};   // see R03
                end
                CMD_RD_IST: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = {15'h0000, ist_r};   // see R02
                end
                `ISES_CMD_RD_EVSTAT: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = {8'h00, evstat};     // see R04
                end
                `ISES_CMD_RD_EVMASK: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = {8'h00, evmask_r};   // see R05
                end
                `ISES_CMD_RD_OPCOND: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = opcond_r;            // see R14
                end
                `ISES_CMD_RD_OPEVT: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = opevt;               // see R14
                end
                `ISES_CMD_RD_OPMASK: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = opmask_r;
                end
                default: begin
                    rsp_valid_nxt = 1'b0;
                    rsp_data_nxt  = 16'h0000;
                end
            endcase
        end
    end

    // Output registers
    always @(posedge clk) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r  <= 16'h0000;
            stb_r       <= 8'h00;
            ist_r       <= 1'b0;
            err_push_r  <= 1'b0;
            err_code_r  <= 16'h0000;
        end else begin
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r  <= rsp_data_nxt;
            stb_r       <= stb_nxt;
            // Bit 6 joins in here, unlike the service request mask
            ist_r       <= |(stb_nxt & ppmask_r);        // see R01
            err_push_r  <= err_push_nxt;
            err_code_r  <= err_code_nxt;
        end
    end

endmodule // ises_top

`default_nettype wire

// [ises_map.vh]
// Purpose: Shared constants of the instrument status event summary block
// Assumes: Included by bare name from the design files
// Notes:   Command codes are the decoded forms of the controller's common
//          and status queries, as handed over by the command parser
`ifndef ISES_MAP_VH
`define ISES_MAP_VH

// Decoded command codes on cmd_code
`define ISES_CMD_W          4
`define ISES_CMD_NOP        4'h0
`define ISES_CMD_WR_PPMASK  4'h1
`define ISES_CMD_RD_PPMASK  4'h2
`define ISES_CMD_RD_IST     4'h3
`define ISES_CMD_RD_EVSTAT  4'h4
`define ISES_CMD_WR_EVMASK  4'h5
`define ISES_CMD_RD_EVMASK  4'h6
`define ISES_CMD_OPC        4'h7
`define ISES_CMD_RD_OPCOND  4'h8
`define ISES_CMD_RD_OPEVT   4'h9
`define ISES_CMD_WR_OPMASK  4'ha
`define ISES_CMD_RD_OPMASK  4'hb

// Event status bit positions
`define ISES_EV_OPC         0
`define ISES_EV_REQCTL      1
`define ISES_EV_QUERY       2
`define ISES_EV_DEVDEP      3
`define ISES_EV_EXEC        4
`define ISES_EV_CMD         5
`define ISES_EV_USER        6
`define ISES_EV_PON         7

// Reset values
`define ISES_EVSTAT_RST     8'h80
`define ISES_EVMASK_RST     8'h00
`define ISES_PPMASK_RST     8'h00
`define ISES_OPMASK_RST     16'h0000

// Operation status bit positions
`define ISES_OP_CAL         0
`define ISES_OP_SETTLE      1
`define ISES_OP_RANGE       2
`define ISES_OP_SWEEP       3
`define ISES_OP_MEAS        4
`define ISES_OP_WTRIG       5
`define ISES_OP_WARM        6
`define ISES_OP_CORR        7
`define ISES_OP_DEV_LO      8
`define ISES_OP_DEV_HI      12
`define ISES_OP_INST        13
`define ISES_OP_PROG        14
`define ISES_OP_ZERO        15

// Status byte bit positions computed here
`define ISES_STB_ESB        5
`define ISES_STB_OPER       7

// Error codes queued per error class (16-bit two's complement)
`define ISES_ERR_DEVDEP     16'hfed4
`define ISES_ERR_EXEC       16'hff38
`define ISES_ERR_CMD        16'hff9c

// Command processing time that settling must exceed
`define ISES_CMD_PROC_NS    200
`define ISES_CLK_NS         10
`define ISES_CMD_PROC_CYC   ((`ISES_CMD_PROC_NS + `ISES_CLK_NS - 1) / `ISES_CLK_NS)

`endif

// [ises_sync3.v]
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   Output follows only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module ises_sync3 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Pin side
    input  wire [W-1:0] d,
    // Clock domain side
    output reg  [W-1:0] q
);

    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer     i;

    always @(posedge clk) begin
        if (!rst_n) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    q[i] <= s3_r[i];
                end
            end
        end
    end

endmodule // ises_sync3

`default_nettype wire

// [ises_evlatch.v]
// Purpose: Sticky event latch with clear on read
// Assumes: set pulses and clr come from logic on clk
// Notes:   A set arriving with the clear survives it
`timescale 1ns/100ps
`default_nettype none

module ises_evlatch #(
    parameter         W   = 8,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Event side
    input  wire [W-1:0] set,
    input  wire         clr,
    // Latched events
    output reg  [W-1:0] q
);

    always @(posedge clk) begin
        if (!rst_n) begin
            q <= RST;
        end else begin
            q <= (q & ~{W{clr}}) | set;
        end
    end

endmodule // ises_evlatch

`default_nettype wire

// [ises_top_chk.sv]
// Purpose: Port-level assertions for the status event summary block
// Assumes: Bound to ises_top; a single clock domain
// Notes:   Only ports are visible, so latched state is judged via answers
`timescale 1ns/100ps
`default_nettype none

module ises_top_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Command and answer
    input wire logic        cmd_valid,
    input wire logic [3:0]  cmd_code,
    input wire logic        rsp_valid_r,
    input wire logic [15:0] rsp_data_r,
    // Error sources
    input wire logic        devdep_err,
    input wire logic        exec_err,
    input wire logic        command_err,
    // Summaries and error push
    input wire logic [7:0]  stb_r,
    input wire logic        ist_r,
    input wire logic        err_push_r,
    input wire logic [15:0] err_code_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire logic is_rd = cmd_valid && (cmd_code inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hb});

    a_cmd_err_code: assert property (command_err |=> err_push_r && err_code_r == 16'hff9c)
        else $error("command error code not pushed");
    a_exec_err_code: assert property (exec_err && !command_err |=> err_code_r == 16'hff38)
        else $error("execution error code not pushed");
    a_dev_err_code: assert property (devdep_err && !exec_err && !command_err
        |=> err_push_r && err_code_r == 16'hfed4)
        else $error("device error code not pushed");
    a_read_answer: assert property (is_rd |=> rsp_valid_r)
        else $error("query not answered next cycle");
    a_write_silent: assert property (cmd_valid && !is_rd |=> !rsp_valid_r)
        else $error("answer after non-query");
    a_ist_answer: assert property (cmd_valid && cmd_code == 4'h3
        |=> rsp_data_r == {15'h0000, $past(ist_r)})
        else $error("flag query answer wrong");
    a_ist_needs_stb: assert property (stb_r == 8'h00 |-> !ist_r)
        else $error("flag set with empty status byte");
    a_op_top_zero: assert property (cmd_valid && cmd_code inside {4'h8, 4'h9}
        |=> rsp_data_r[15] == 1'b0)
        else $error("operation bit 15 reads one");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n
        |=> stb_r == 8'h00 && !ist_r && !rsp_valid_r && !err_push_r)
        else $error("outputs active after reset edge");

    c_err_push: cover property (err_push_r);
    c_ist_up: cover property (ist_r);
    c_pon_read: cover property (rsp_valid_r && rsp_data_r[7]);
endmodule // ises_top_chk

`default_nettype wire

// [ises_ctl_model.sv]
// Purpose: Bus controller model issuing decoded commands and taking answers
// Assumes: Drives on the falling edge; one command per call
// Notes:   Released data is inverted so stale values cannot pass as valid
`timescale 1ns/100ps
`default_nettype none

module ises_ctl_model (
    // Clock
    input wire logic         clk,
    // Command side
    output var logic         cmd_valid,
    output var logic [3:0]   cmd_code,
    output var logic [15:0]  cmd_data,
    // Answer side
    input wire logic         rsp_valid_r,
    input wire logic [15:0]  rsp_data_r
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 4'h0;
        cmd_data = 16'h0000;
    end

    task automatic xfer(input logic [3:0] code, input logic [15:0] data,
                        output logic v, output logic [15:0] d);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_data = data;
        // The answer stands only for the cycle after the taking edge
        @(negedge clk);
        v = rsp_valid_r;
        d = rsp_data_r;
        cmd_valid = 1'b0;
        cmd_code = 4'h0;
        cmd_data = ~data;
    endtask
endmodule // ises_ctl_model

`default_nettype wire

// [test_instrument_status_event_summary.sv]
// Purpose: Self-checking bench for the status event summary block
// Assumes: Settling count shortened to 2 cycles
// Notes:   Ordinary event cases run from a table, the rest by hand
`timescale 1ns/100ps
`default_nettype none

module test_instrument_status_event_summary;
    typedef struct packed {
        logic [2:0]  src;
        logic [7:0]  ev;
        logic        push;
        logic [15:0] code;
    } ises_row_t;

    logic        clk;
    logic        rst_n;
    logic        cmd_valid;
    logic [3:0]  cmd_code;
    logic [15:0] cmd_data;
    logic        rsp_valid_r;
    logic [15:0] rsp_data_r;
    logic        exec_idle;
    logic        local_key;
    logic [4:0]  evp;
    logic [14:0] oplv;
    logic [7:0]  stb_ext;
    logic [7:0]  stb_r;
    logic        ist_r;
    logic        err_push_r;
    logic [15:0] err_code_r;
    logic        gv;
    logic [15:0] gd;
    logic        rsp_valid_n;
    logic [15:0] rsp_data_n;
    int          error_cnt;
    int          n_compared;
    ises_row_t   rows [5] = '{'{3'd0, 8'h02, 1'b0, 16'h0000}, '{3'd1, 8'h04, 1'b0, 16'h0000},
                              '{3'd2, 8'h08, 1'b1, 16'hfed4}, '{3'd3, 8'h10, 1'b1, 16'hff38},
                              '{3'd4, 8'h20, 1'b1, 16'hff9c}};

    ises_ctl_model m_ctl (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r));

    ises_top #(.OP_IMPL(1), .SETTLE_CYC(2)) i_dut (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
        .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r), .exec_idle(exec_idle),
        .ctl_request(evp[0]), .query_err(evp[1]), .devdep_err(evp[2]), .exec_err(evp[3]),
        .command_err(evp[4]), .local_key(local_key), .calibrating(oplv[0]),
        .settling(oplv[1]), .ranging(oplv[2]), .sweeping(oplv[3]), .measuring(oplv[4]),
        .wait_trigger(oplv[5]), .wait_arm(oplv[6]), .correcting(oplv[7]),
        .dev_activity(oplv[12:8]), .inst_summary(oplv[13]), .prog_running(oplv[14]),
        .stb_ext(stb_ext), .stb_r(stb_r), .ist_r(ist_r), .err_push_r(err_push_r),
        .err_code_r(err_code_r));

    // Same stimulus with the operation register left inactive
    ises_top #(.OP_IMPL(0), .SETTLE_CYC(2)) i_dut_op_off (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
        .rsp_valid_r(rsp_valid_n), .rsp_data_r(rsp_data_n), .exec_idle(exec_idle),
        .ctl_request(evp[0]), .query_err(evp[1]), .devdep_err(evp[2]), .exec_err(evp[3]),
        .command_err(evp[4]), .local_key(local_key), .calibrating(oplv[0]),
        .settling(oplv[1]), .ranging(oplv[2]), .sweeping(oplv[3]), .measuring(oplv[4]),
        .wait_trigger(oplv[5]), .wait_arm(oplv[6]), .correcting(oplv[7]),
        .dev_activity(oplv[12:8]), .inst_summary(oplv[13]), .prog_running(oplv[14]),
        .stb_ext(stb_ext), .stb_r(), .ist_r(), .err_push_r(), .err_code_r());

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [3:0] code, input logic [15:0] exp);
        m_ctl.xfer(code, 16'h0000, gv, gd);
        chk({15'h0000, gv}, 16'h0001);
        chk(gd, exp);
    endtask

    task automatic wr(input logic [3:0] code, input logic [15:0] data);
        m_ctl.xfer(code, data, gv, gd);
        chk({15'h0000, gv}, 16'h0000);
    endtask

    task automatic pulse(input int idx);
        @(negedge clk);
        evp[idx] = 1'b1;
        @(negedge clk);
        // Returns while the error push caused by the pulse still stands
        evp = 5'h00;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic close_out;
        $display("compares %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Run takes about 130 cycles; 3000 leaves ample margin
    initial begin
        #30000;
        error_cnt++;
        close_out;
    end

    initial begin
        rst_n = 1'b0;
        exec_idle = 1'b0;
        local_key = 1'b0;
        evp = 5'h00;
        oplv = 15'h0000;
        stb_ext = 8'h00;
        error_cnt = 0;
        n_compared = 0;
        idle(12);
        rst_n = 1'b1;
        chk({8'h00, stb_r}, 16'h0000);
        rd(4'h4, 16'h0080);
        rd(4'h4, 16'h0000);
        rd(4'h2, 16'h0000);
        rd(4'h6, 16'h0000);
        foreach (rows[i]) begin
            pulse(rows[i].src);
            chk({15'h0000, err_push_r}, {15'h0000, rows[i].push});
            if (rows[i].push)
                chk(err_code_r, rows[i].code);
            rd(4'h4, {8'h00, rows[i].ev});
        end
        wr(4'h1, 16'h00a5);
        rd(4'h2, 16'h00a5);
        wr(4'h5, 16'h005a);
        rd(4'h6, 16'h005a);
        wr(4'h5, 16'h0010);
        wr(4'h1, 16'h0020);
        pulse(3);
        idle(1);
        chk({15'h0000, stb_r[5]}, 16'h0001);
        chk({15'h0000, ist_r}, 16'h0001);
        rd(4'h3, 16'h0001);
        rd(4'h4, 16'h0010);
        idle(2);
        chk({15'h0000, ist_r}, 16'h0000);
        stb_ext = 8'h40;
        wr(4'h1, 16'h0040);
        idle(2);
        chk({15'h0000, ist_r}, 16'h0001);
        stb_ext = 8'h00;
        wr(4'h7, 16'h0000);
        idle(5);
        rd(4'h4, 16'h0000);
        exec_idle = 1'b1;
        idle(3);
        rd(4'h4, 16'h0001);
        local_key = 1'b1;
        idle(10);
        local_key = 1'b0;
        idle(8);
        rd(4'h4, 16'h0040);
        wr(4'ha, 16'h0008);
        oplv = 15'h7ffd;
        idle(3);
        rd(4'h8, 16'h7ffd);
        chk({15'h0000, rsp_valid_n}, 16'h0001);
        chk(rsp_data_n, 16'h0000);
        chk({15'h0000, stb_r[7]}, 16'h0001);
        rd(4'h9, 16'h7ffd);
        rd(4'h9, 16'h0000);
        rd(4'hb, 16'h0008);
        oplv = 15'h7fff;
        rd(4'h8, 16'h7ffd);
        idle(8);
        rd(4'h8, 16'h7fff);
        wr(4'hc, 16'h0000);
        rst_n = 1'b0;
        idle(2);
        rst_n = 1'b1;
        rd(4'h6, 16'h0000);
        rd(4'h4, 16'h0080);
        close_out;
    end
endmodule // test_instrument_status_event_summary

bind ises_top ises_top_chk i_chk (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r),
    .devdep_err(devdep_err), .exec_err(exec_err), .command_err(command_err),
    .stb_r(stb_r), .ist_r(ist_r), .err_push_r(err_push_r), .err_code_r(err_code_r));

`default_nettype wire
